// ===== common/ectt_cfg.svh
// register offsets, field positions, reset values and timing of the compare/capture timer
`ifndef ECTT_CFG_SVH
`define ECTT_CFG_SVH
// register offsets
`define ECTT_A_MODE   8'h00
`define ECTT_A_CMODE1 8'h01
`define ECTT_A_CMODE2 8'h02
`define ECTT_A_CTRL   8'h03
`define ECTT_A_CLKSEL 8'h04
`define ECTT_A_CMP1   8'h05
`define ECTT_A_CMP2   8'h06
`define ECTT_A_CAPT   8'h07
`define ECTT_A_ISTAT  8'h08
`define ECTT_A_IMASK  8'h09
`define ECTT_A_STATE  8'h0A
// compare-mode fields
`define ECTT_CM_IRQ   0
`define ECTT_CM_RST   1
`define ECTT_CM_TOG   2
`define ECTT_CM_SA    3
// control fields
`define ECTT_CT_RUN   0
`define ECTT_CT_PRE   1
`define ECTT_CT_EIM   2
// clock-select fields: bit 0 external clock, bits 2:1 edge select
`define ECTT_CS_EXT   0
`define ECTT_CS_EDGE  1
// interrupt status bits
`define ECTT_IS_CMP1  0
`define ECTT_IS_CMP2  1
`define ECTT_IS_EXT   2
// reset values
`define ECTT_RST_MODE  4'hF
`define ECTT_RST_CMODE 4'h0
`define ECTT_RST_CTRL  3'h0
`define ECTT_RST_CLKS  3'h0
`define ECTT_RST_CMP   8'hFF
// synchroniser depth on the timer input
`define ECTT_SYNC_STAGES 2
`endif

// ===== common/ectt_pkg.sv
// types shared by the compare/capture timer
package ectt_pkg;
   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ectt_req_t;
   // counter sequencing
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_RUN
   } ectt_state_t;
endpackage : ectt_pkg

// ===== rtl/ectt_edge.sv
// timer input synchroniser with programmable edge decoder
`timescale 1ns/1ps
`include "ectt_cfg.svh"
module ectt_edge (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // pin and edge choice: 01 rising, 10 falling, 11 both, 00 none
   input  wire logic       pin,
   input  wire logic [1:0] edge_sel,
   // synchronised level and one-cycle edge pulse
   output logic            level,
   output logic            edge_pulse
);
   logic meta;
   logic prev;
   wire  rise = level & ~prev;
   wire  fall = ~level & prev;

   // two synchroniser flops plus one for the edge; only the second one is looked at, stops with the clock
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta  <= 1'b0;
         level <= 1'b0;
         prev  <= 1'b0;
      end else begin
         meta  <= pin;
         level <= meta;
         prev  <= level;
      end
   end

   // active edge choice
   assign edge_pulse = (edge_sel[0] & rise) | (edge_sel[1] & fall);
endmodule : ectt_edge

// ===== rtl/ectt_timer.sv
// eight-bit up-counter with two compare registers, capture, trigger and modem modes
// Behaviour
// - 8-bit up-counter, two compares, one capture
// - timer input resynchronised to system clock
// - capture register shows running count outside capture modes
// - capture on timer input or companion toggle
// - trigger mode waits for input edge
// - single action: one match per start
// - match resets, interrupts, toggles per mask
// - compares alternate register 1 then 2
// - after single action, other register only
// - six timer and six modem modes
// - control starts, stops, presets output level
// - input edge interrupt only while stopped
// - clock source and active edge select
// - input serves clock, capture or trigger
// - modulator encodes each shifted bit
// - demodulated bits shift out automatically
// - compare value x matches after x+1 counts
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "ectt_cfg.svh"
module ectt_timer #(
   parameter int CW = 8
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   // register port
   input  wire ectt_pkg::ectt_req_t req,
   output logic [7:0]            rdata,
   // pin and companion timer
   input  wire logic             timer_ext_input,
   input  wire logic             timer2_toggle_pulse,
   input  wire logic             timer2_output,
   // serial shift register
   input  wire logic             ser_data_out,
   output logic                  shift_strobe,
   output logic                  shift_bit,
   // outputs
   output logic                  timer_out,
   output logic                  toggle_pulse,
   output logic                  irq
);
   // registers
   logic [3:0]          timer_mode_reg;
   logic [3:0]          compare_mode_reg_one;
   logic [3:0]          compare_mode_reg_two;
   logic [2:0]          timer_control_reg;
   logic [2:0]          clk_sel_reg;
   logic [CW-1:0]       cmp1;
   logic [CW-1:0]       cmp2;
   logic [CW-1:0]       capt;
   logic [2:0]          istat;
   logic [2:0]          imask;
   // core state
   logic [CW-1:0]       count;
   logic                sel;
   logic [1:0]          sa_done;
   logic                out_ff;
   logic                bp_ff;
   ectt_pkg::ectt_state_t state;
   ectt_pkg::ectt_state_t next_state;
   logic                ext_lvl;
   logic                ext_edge;

   // timer input stage
   ectt_edge u_edge (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .pin        (timer_ext_input),
      .edge_sel   (clk_sel_reg[`ECTT_CS_EDGE +: 2]),
      .level      (ext_lvl),
      .edge_pulse (ext_edge)
   );

   // mode decode; unused codes behave as mode 1
   wire timer_run_bit = timer_control_reg[`ECTT_CT_RUN];
   wire md_trig  = (timer_mode_reg == 4'h2) || (timer_mode_reg == 4'h5);
   wire md_int   = (timer_mode_reg == 4'h3);
   wire md_t2out = (timer_mode_reg == 4'h4) || (timer_mode_reg == 4'h5);
   wire md_burst2 = (timer_mode_reg == 4'h6);
   wire md_burso = (timer_mode_reg == 4'h7);
   wire md_fsk   = (timer_mode_reg == 4'h8) || (timer_mode_reg == 4'h9);
   wire md_man   = (timer_mode_reg == 4'hA);
   wire md_bip   = (timer_mode_reg == 4'hB);
   wire md_dem   = md_man || md_bip;
   wire md_xcap  = (timer_mode_reg == 4'hC);

   // register decode
   wire wr_mode  = req.wr && (req.addr == `ECTT_A_MODE);
   wire wr_cm1   = req.wr && (req.addr == `ECTT_A_CMODE1);
   wire wr_cm2   = req.wr && (req.addr == `ECTT_A_CMODE2);
   wire wr_ctrl  = req.wr && (req.addr == `ECTT_A_CTRL);
   wire wr_clks  = req.wr && (req.addr == `ECTT_A_CLKSEL);
   wire wr_cmp1  = req.wr && (req.addr == `ECTT_A_CMP1);
   wire wr_cmp2  = req.wr && (req.addr == `ECTT_A_CMP2);
   wire wr_istat = req.wr && (req.addr == `ECTT_A_ISTAT);
   wire wr_imask = req.wr && (req.addr == `ECTT_A_IMASK);

   // the input is the counting clock only in modes that do not use it as an event
   wire ext_clk_en = clk_sel_reg[`ECTT_CS_EXT] && !md_trig && !md_xcap && !md_dem;
   wire counting   = (state == ectt_pkg::ST_RUN);
   wire tick       = counting && (ext_clk_en ? ext_edge : 1'b1);

   // compare register in use: shift data picks it in fsk and pwm
   wire          eff_sel = md_fsk ? ser_data_out : sel;
   wire [CW-1:0] cmp_cur = eff_sel ? cmp2 : cmp1;
   wire [3:0]    cm_cur  = eff_sel ? compare_mode_reg_two : compare_mode_reg_one;
   // a spent single-action register gives no event
   wire hit = tick && (count == cmp_cur) && !sa_done[eff_sel];
   wire hit1 = hit && !eff_sel;
   wire hit2 = hit && eff_sel;

   // capture and restart events
   wire run_edge_ok = timer_run_bit;
   wire trig_edge = run_edge_ok && md_trig && ext_edge && (state == ectt_pkg::ST_RUN);
   wire cap_evt  = trig_edge || (timer_run_bit && md_int && timer2_toggle_pulse) ||
                   (timer_run_bit && md_xcap && ext_edge);
   wire cap_live = !md_trig && !md_int && !md_xcap;
   // demodulator resynchronises on the first edge after the bit was taken
   wire dem_sync = timer_run_bit && md_dem && ext_edge && sel;
   wire restart  = (cap_evt && !md_xcap) || dem_sync;

   // single-action bookkeeping and the next register in the alternation
   wire [1:0] sa_set  = (hit && cm_cur[`ECTT_CM_SA]) ? (eff_sel ? 2'b10 : 2'b01) : 2'b00;
   wire [1:0] sa_next = sa_done | sa_set;
   wire       sel_alt = sa_next[~eff_sel] ? eff_sel : ~eff_sel;

   // counter next value; wraps when no reset is enabled
   logic [CW-1:0] next_count;
   always_comb begin
      next_count = count;
      if (!timer_run_bit || restart) begin
         next_count = '0;
      end else if (hit && cm_cur[`ECTT_CM_RST]) begin
         next_count = '0;
      end else if (tick) begin
         next_count = CW'(count + 1'b1);
      end
   end

   // sequencing: armed state waits for the trigger edge
   always_comb begin
      next_state = state;
      unique case (state)
         ectt_pkg::ST_IDLE: begin
            if (timer_run_bit) begin
               next_state = md_trig ? ectt_pkg::ST_ARMED : ectt_pkg::ST_RUN;
            end
         end
         ectt_pkg::ST_ARMED: begin
            if (ext_edge) begin
               next_state = ectt_pkg::ST_RUN;
            end
         end
         ectt_pkg::ST_RUN: begin
            next_state = ectt_pkg::ST_RUN;
         end
      endcase
      if (!timer_run_bit) begin
         next_state = ectt_pkg::ST_IDLE;
      end
   end

   // counter, alternation and state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count   <= '0;
         sel     <= 1'b0;
         sa_done <= 2'b00;
         state   <= ectt_pkg::ST_IDLE;
      end else begin
         count   <= next_count;
         state   <= next_state;
         if (!timer_run_bit || restart) begin
            sel     <= 1'b0;
            sa_done <= 2'b00;
         end else if (hit) begin
            sel     <= sel_alt;
            sa_done <= sa_next;
         end
      end
   end

   // output flip-flop: preset while stopped, toggled by enabled matches
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         out_ff <= 1'b0;
      end else if (!timer_run_bit) begin
         out_ff <= timer_control_reg[`ECTT_CT_PRE];
      end else if (hit && cm_cur[`ECTT_CM_TOG]) begin
         out_ff <= ~out_ff;
      end
   end

   // biphase decoder flip-flop: toggled by mid-frame edges, cleared when the bit is taken
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bp_ff <= 1'b0;
      end else if (!md_bip || !timer_run_bit || (hit1 && md_dem)) begin
         bp_ff <= 1'b0;
      end else if (ext_edge && !sel) begin
         bp_ff <= ~bp_ff;
      end
   end

   // output stage: burst gating and pass-through of the companion output
   wire out_sel = md_t2out  ? timer2_output :
                  md_burst2 ? (out_ff & timer2_output) :
                  md_burso  ? (out_ff & ser_data_out) : out_ff;

   // registered outputs; demodulated bits go to the shift register unasked
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timer_out    <= 1'b0;
         toggle_pulse <= 1'b0;
         shift_strobe <= 1'b0;
         shift_bit    <= 1'b0;
      end else begin
         timer_out    <= out_sel;
         toggle_pulse <= hit && cm_cur[`ECTT_CM_TOG];
         shift_strobe <= md_dem && hit1;
         shift_bit    <= md_man ? ext_lvl : bp_ff;
      end
   end

   // capture: follows the count outside capture modes, so it can be read on the fly
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         capt <= '0;
      end else if (cap_live || cap_evt) begin
         capt <= count;
      end
   end

   // interrupt events; the input edge counts only while stopped
   wire [2:0] ev_set;
   assign ev_set[`ECTT_IS_CMP1] = hit1 && compare_mode_reg_one[`ECTT_CM_IRQ];
   assign ev_set[`ECTT_IS_CMP2] = hit2 && compare_mode_reg_two[`ECTT_CM_IRQ];
   assign ev_set[`ECTT_IS_EXT]  = ext_edge && timer_control_reg[`ECTT_CT_EIM] && !timer_run_bit;

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         istat <= 3'h0;
      end else begin
         istat <= (istat & ~(wr_istat ? req.wdata[2:0] : 3'h0)) | ev_set;
      end
   end
   assign irq = |(istat & imask);

   // software registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timer_mode_reg       <= `ECTT_RST_MODE;
         compare_mode_reg_one <= `ECTT_RST_CMODE;
         compare_mode_reg_two <= `ECTT_RST_CMODE;
         timer_control_reg    <= `ECTT_RST_CTRL;
         clk_sel_reg          <= `ECTT_RST_CLKS;
         cmp1                 <= `ECTT_RST_CMP;
         cmp2                 <= `ECTT_RST_CMP;
         imask                <= 3'h0;
      end else begin
         if (wr_mode)  timer_mode_reg       <= req.wdata[3:0];
         if (wr_cm1)   compare_mode_reg_one <= req.wdata[3:0];
         if (wr_cm2)   compare_mode_reg_two <= req.wdata[3:0];
         if (wr_ctrl)  timer_control_reg    <= req.wdata[2:0];
         if (wr_clks)  clk_sel_reg          <= req.wdata[2:0];
         if (wr_cmp1)  cmp1                 <= req.wdata[CW-1:0];
         if (wr_cmp2)  cmp2                 <= req.wdata[CW-1:0];
         if (wr_imask) imask                <= req.wdata[2:0];
      end
   end

   // read selection; unmapped addresses read zero
   wire [7:0] st_word = {4'h0, sa_done, sel, counting};
   wire [7:0] rd_mux =
      (req.addr == `ECTT_A_MODE)   ? {4'h0, timer_mode_reg} :
      (req.addr == `ECTT_A_CMODE1) ? {4'h0, compare_mode_reg_one} :
      (req.addr == `ECTT_A_CMODE2) ? {4'h0, compare_mode_reg_two} :
      (req.addr == `ECTT_A_CTRL)   ? {5'h00, timer_control_reg} :
      (req.addr == `ECTT_A_CLKSEL) ? {5'h00, clk_sel_reg} :
      (req.addr == `ECTT_A_CMP1)   ? 8'(cmp1) :
      (req.addr == `ECTT_A_CMP2)   ? 8'(cmp2) :
      (req.addr == `ECTT_A_CAPT)   ? 8'(capt) :
      (req.addr == `ECTT_A_ISTAT)  ? {5'h00, istat} :
      (req.addr == `ECTT_A_IMASK)  ? {5'h00, imask} :
      (req.addr == `ECTT_A_STATE)  ? st_word : 8'h00;

   // read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= req.rd ? rd_mux : 8'h00;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_arm;
      state == ectt_pkg::ST_ARMED && timer_run_bit && !ext_edge;
   endsequence
   sequence s_stay;
      state == ectt_pkg::ST_ARMED && count == '0;
   endsequence

   property p_wrap;
      tick && count == {CW{1'b1}} && !hit && !restart && timer_run_bit |=> count == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_match_at;
      hit && cm_cur[`ECTT_CM_RST] && timer_run_bit && !restart |=> count == '0;
   endproperty
   a_match_at: assert property (p_match_at) else $error("match did not reset the count");

   property p_alternate;
      hit && !md_fsk && !cm_cur[`ECTT_CM_SA] && !sa_done[~sel] && timer_run_bit && !restart
         |=> sel != $past(sel);
   endproperty
   a_alternate: assert property (p_alternate) else $error("compare register not alternated");

   property p_single;
      sa_done[0] && !sa_done[1] && !md_fsk && timer_run_bit && !restart |=> sel;
   endproperty
   a_single: assert property (p_single) else $error("spent single action register used again");

   property p_stop;
      !timer_run_bit |=> count == '0 && !sel && sa_done == 2'b00;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not clear");

   property p_ext_irq;
      $rose(istat[`ECTT_IS_EXT]) |-> $past(timer_control_reg[`ECTT_CT_EIM] && !timer_run_bit);
   endproperty
   a_ext_irq: assert property (p_ext_irq) else $error("input interrupt while running");

   property p_toggle;
      hit && cm_cur[`ECTT_CM_TOG] && timer_run_bit |=> out_ff != $past(out_ff) && toggle_pulse;
   endproperty
   a_toggle: assert property (p_toggle) else $error("match did not toggle");

   property p_capture;
      cap_evt |=> capt == $past(count);
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed");

   property p_trigger;
      s_arm |=> s_stay or state == ectt_pkg::ST_IDLE;
   endproperty
   a_trigger: assert property (p_trigger) else $error("counter ran before trigger");
endmodule : ectt_timer

// ===== sim/ectt_partner.sv
// companion timer and serial shift register on the far side of the timer
`timescale 1ns/1ps
module ectt_partner #(
   parameter int DIV = 4
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // from the timer
   input  wire logic t3_toggle,
   input  wire logic shift_strobe,
   input  wire logic shift_bit,
   // to the timer
   output logic      t2_toggle,
   output logic      t2_out,
   output logic      so
);
   int         cnt;
   logic [7:0] sreg;
   // shift register data output is its top bit
   assign so = sreg[7];
   // companion divides timer toggles, so its output changes slower than the carrier
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt       <= 0;
         t2_toggle <= 1'b0;
         t2_out    <= 1'b0;
         sreg      <= 8'hA5;
      end else begin
         t2_toggle <= 1'b0;
         if (t3_toggle) begin
            cnt <= (cnt + 1) % DIV;
            if (cnt == DIV - 1) begin
               t2_toggle <= 1'b1;
               t2_out    <= ~t2_out;
            end
         end
         // decoded bits win over the companion shift clock
         if (shift_strobe) begin
            sreg <= {sreg[6:0], shift_bit};
         end else if (t2_toggle) begin
            sreg <= {sreg[6:0], sreg[7]};
         end
      end
   end
endmodule : ectt_partner

// ===== sim/tb.sv
// self-checking bench for the compare/capture timer
`timescale 1ns/1ps
`include "ectt_cfg.svh"
module tb;
   logic                ref_clk = 1'b0;
   logic                rstn    = 1'b0;
   ectt_pkg::ectt_req_t req     = '0;
   logic                pin     = 1'b0;
   logic [7:0]          rdata;
   logic                t2_tog, t2_out, so, sh_stb, sh_bit, t_out, tog, irq;
   int                  fail_count  = 0;
   int                  checks_done = 0;
   int                  seed        = 1;
   int                  n, k, m;
   logic [7:0]          d, c1, c2, cap;
   logic                t2p;
   logic [7:0]          cs[3]  = '{8'h03, 8'h05, 8'h07};
   int                  mul[3] = '{1, 1, 2};
   logic [7:0]          ev_ctrl[3] = '{8'h04, 8'h00, 8'h05};
   logic                ev_exp[3]  = '{1'b1, 1'b0, 1'b0};

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   ectt_timer #(.CW(8)) dut (
      .ref_clk(ref_clk), .rstn(rstn), .req(req), .rdata(rdata), .timer_ext_input(pin),
      .timer2_toggle_pulse(t2_tog), .timer2_output(t2_out), .ser_data_out(so),
      .shift_strobe(sh_stb), .shift_bit(sh_bit), .timer_out(t_out), .toggle_pulse(tog), .irq(irq));

   ectt_partner #(.DIV(4)) u_far (
      .ref_clk(ref_clk), .rstn(rstn), .t3_toggle(tog), .shift_strobe(sh_stb), .shift_bit(sh_bit),
      .t2_toggle(t2_tog), .t2_out(t2_out), .so(so));

   // comparisons: one per kind of result
   task chk_reg(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg
   task chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   task chk_cyc(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_cyc

   // register bus: one-cycle strobes, read data in the following cycle
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
      #1;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 v = rdata;
   endtask : rd
   task rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk_reg(v, exp);
   endtask : rdchk

   // stop, program, then start; a restart always begins from a clean count
   task start_cfg(input logic [7:0] md, m1, m2, a, b);
      wr(`ECTT_A_CTRL, 8'h00);
      wr(`ECTT_A_MODE, md);
      wr(`ECTT_A_CMODE1, m1);
      wr(`ECTT_A_CMODE2, m2);
      wr(`ECTT_A_CMP1, a);
      wr(`ECTT_A_CMP2, b);
      wr(`ECTT_A_CTRL, 8'h01);
   endtask : start_cfg

   // cycles up to the next pulse, bounded so a dead output cannot hang the run
   task wait_pulse(input logic use_sh, output int cyc);
      cyc = 0;
      do begin
         @(posedge ref_clk);
         #1;
         cyc++;
      end while (((use_sh ? sh_stb : tog) !== 1'b1) && cyc < 600);
      if (cyc >= 600) chk_cyc(cyc, 0);
   endtask : wait_pulse

   // model: after a sync pulse, gaps alternate b, a, b, ...
   task gaps(input int a, input int b, input int cnt);
      int g;
      int exp_q[$];
      for (int i = 0; i < cnt; i++) begin
         exp_q.push_back((i % 2 == 0) ? b : a);
      end
      wait_pulse(1'b0, g);
      while (exp_q.size() > 0) begin
         wait_pulse(1'b0, g);
         chk_cyc(g, exp_q.pop_front());
      end
   endtask : gaps

   // one rising and one falling edge, spaced past the synchroniser
   task pin_edge;
      @(posedge ref_clk);
      pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : pin_edge

   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   // watchdog: the tests need well under 10000 cycles
   initial begin
      #(40 * 30000);
      fail_count++;
      print_verdict;
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      rdchk(`ECTT_A_MODE, 8'h0F);
      rdchk(`ECTT_A_CMP2, 8'hFF);
      rdchk(`ECTT_A_CTRL, 8'h00);
      rdchk(8'h3C, 8'h00);
      chk_bit(irq, 1'b0);
      $display("test reset_values done");
      c1 = 8'(($random(seed) & 15) + 2);
      c2 = 8'(($random(seed) & 15) + 2);
      wr(`ECTT_A_IMASK, 8'h01);
      start_cfg(8'h01, 8'h07, 8'h06, c1, c2);
      rdchk(`ECTT_A_CMP1, c1);
      gaps(int'(c1) + 1, int'(c2) + 1, 4);
      chk_bit(irq, 1'b1);
      wr(`ECTT_A_CTRL, 8'h00);
      wr(`ECTT_A_ISTAT, 8'h03);
      chk_bit(irq, 1'b0);
      rdchk(`ECTT_A_STATE, 8'h00);
      rdchk(`ECTT_A_CAPT, 8'h00);
      $display("test alternation done");
      start_cfg(8'h01, 8'h0E, 8'h06, c1, c2);
      gaps(int'(c2) + 1, int'(c2) + 1, 3);
      start_cfg(8'h01, 8'h04, 8'h04, c1, c1);
      gaps(256, 256, 2);
      $display("test single_action_wrap done");
      // the preset reaches the output flip-flop, then the output register
      wr(`ECTT_A_CTRL, 8'h02);
      repeat (2) @(posedge ref_clk);
      #1 chk_bit(t_out, 1'b1);
      wr(`ECTT_A_CTRL, 8'h00);
      repeat (2) @(posedge ref_clk);
      #1 chk_bit(t_out, 1'b0);
      $display("test preset done");
      // input edge interrupt: stopped with mask, stopped without, running
      start_cfg(8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF);
      wr(`ECTT_A_CLKSEL, 8'h02);
      wr(`ECTT_A_IMASK, 8'h04);
      for (int i = 0; i < 3; i++) begin
         wr(`ECTT_A_CTRL, ev_ctrl[i]);
         pin_edge;
         chk_bit(irq, ev_exp[i]);
         wr(`ECTT_A_ISTAT, 8'h04);
      end
      $display("test input_irq done");
      // external clock on rising, falling and both edges
      for (int i = 0; i < 3; i++) begin
         k = 3 + ($random(seed) & 3);
         wr(`ECTT_A_CTRL, 8'h00);
         wr(`ECTT_A_CLKSEL, cs[i]);
         start_cfg(8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF);
         repeat (k) pin_edge;
         rdchk(`ECTT_A_CAPT, 8'(k * mul[i]));
      end
      $display("test ext_clock done");
      // edge capture: two captures a known number of cycles apart
      wr(`ECTT_A_CTRL, 8'h00);
      wr(`ECTT_A_CLKSEL, 8'h02);
      start_cfg(8'h0C, 8'h00, 8'h00, 8'hFF, 8'hFF);
      m = $random(seed) & 63;
      pin_edge;
      rd(`ECTT_A_CAPT, cap);
      repeat (m) @(posedge ref_clk);
      pin_edge;
      rd(`ECTT_A_CAPT, d);
      chk_reg(d - cap, 8'(m + 11));
      $display("test capture done");
      // trigger: armed and idle until the input edge
      start_cfg(8'h02, 8'h00, 8'h00, 8'hFF, 8'hFF);
      repeat (5) @(posedge ref_clk);
      rd(`ECTT_A_STATE, d);
      chk_bit(d[0], 1'b0);
      pin_edge;
      rd(`ECTT_A_STATE, d);
      chk_bit(d[0], 1'b1);
      $display("test trigger done");
      // demodulation: compare 1 match shifts the input level
      wr(`ECTT_A_CTRL, 8'h00);
      wr(`ECTT_A_CLKSEL, 8'h06);
      for (int b = 1; b >= 0; b--) begin
         @(posedge ref_clk);
         pin <= 1'(b);
         start_cfg(8'h0A, 8'h02, 8'h00, 8'h05, 8'hFF);
         wait_pulse(1'b1, n);
         chk_bit(sh_bit, 1'(b));
      end
      $display("test demod done");
      // companion toggle captures: it answers one cycle after our toggle, so the count has reached one
      start_cfg(8'h03, 8'h06, 8'h06, 8'h03, 8'h03);
      repeat (40) @(posedge ref_clk);
      rdchk(`ECTT_A_CAPT, 8'h01);
      // companion output passes through with one register of delay
      start_cfg(8'h04, 8'h06, 8'h06, 8'h01, 8'h01);
      @(posedge ref_clk);
      #1 t2p = t2_out;
      repeat (24) begin
         @(posedge ref_clk);
         #1 chk_bit(t_out, t2p);
         t2p = t2_out;
      end
      // biphase: one mid-frame edge gives a one, a quiet frame a zero
      start_cfg(8'h0B, 8'h02, 8'h00, 8'h14, 8'hFF);
      @(posedge ref_clk);
      pin <= ~pin;
      wait_pulse(1'b1, n);
      chk_bit(sh_bit, 1'b1);
      wait_pulse(1'b1, n);
      chk_bit(sh_bit, 1'b0);
      $display("test companion_biphase done");
      print_verdict;
   end
endmodule : tb
